// ### fawc_core_model.sv
// Purpose: Bus master model fetching code and data through the bridge
// Assumes: One read at a time, held until the ready edge
// Notes: Latency counts edges from the drive edge to the visible ready pulse
`timescale 1ns/1ps
module fawc_core_model (
    input wire logic clock_in,
    input wire logic ready_in,
    output fawc_pkg::fawc_read_t read_out
);
    initial read_out = '0;

    // Holds the request until ready is sampled, then scrambles the idle fields
    task automatic fetch(input fawc_pkg::fawc_read_t r, output int lat);
        fawc_pkg::fawc_read_t idle;
        lat = 0;
        idle = ~r;
        idle.valid = 1'b0;
        @(posedge clock_in);
        read_out <= r;
        while (lat < 40) begin
            @(posedge clock_in);
            #1;
            lat = lat + 1;
            if (ready_in === 1'b1) break;
        end
        @(posedge clock_in);
        read_out <= idle;
        repeat (12) @(posedge clock_in);
    endtask
endmodule

// ### fawc_flash_ctrl.sv
// Purpose: Flash read wait-state insertion and program/erase arbitration
// Assumes: Reads arrive from the internal memory bridge one at a time
// Notes: Times counted on the system clock; long counts are parameters
//
// Operation
// - After reset sectors read erased and no protection is active
// - Any module not being read may be written while reads use at most one module or RAM
// - A module supplying reads is never written at the same time; checked only at op acceptance, reads of a busy module still served
// - With reads from several modules only module 4 may be written
// - Sector erase completes within 8.0 ms
// - Page program completes within 3.5 ms
// - Sequencer adds a few system clocks to each operation
// - Non-cacheable wait states apply only to non-sequential reads; prefetch serves sequential
// - Cacheable reads add one wait on miss and none on hit
`timescale 1ns/1ps
module fawc_flash_ctrl #(
    parameter int ERASE_CYC = fawc_pkg::ERASE_CYCLES,
    parameter int PROG_CYC = fawc_pkg::PROG_CYCLES
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire fawc_pkg::fawc_read_t read_in,
    input wire logic [2:0] base_access_wait_count_in,
    input wire logic [1:0] access_wait_extension_in,
    input wire logic safe_access_after_reset_in,
    input wire logic [4:0] modules_being_read_in,
    input wire logic program_ram_fetch_in,
    input wire fawc_pkg::fawc_op_t op_in,
    output logic read_ready_out,
    output logic read_erased_out,
    output logic protect_active_out,
    output logic op_accepted_out,
    output logic op_refused_out,
    output logic op_done_out,
    output logic [4:0] busy_out
);
    // Number of distinct flash modules currently serving reads
    function automatic logic [2:0] count_mods(input logic [4:0] m);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < fawc_pkg::N_MODULES; i++) begin
            c = c + {2'h0, m[i]};
        end
        return c;
    endfunction

    fawc_pkg::fawc_state_t state, next_state;
    logic [16:0] timer, next_timer;
    logic [2:0] op_mod, next_op_mod;
    logic [4:0] written, next_written;
    logic [4:0] busy, next_busy;
    logic accepted, next_accepted;
    logic refused, next_refused;
    logic done, next_done;
    logic [3:0] wcount, next_wcount;
    logic rbusy, next_rbusy;
    logic ready, next_ready;
    logic safe_seen, next_safe_seen;
    logic erased, next_erased;
    logic [3:0] waits;
    logic [4:0] read_mods;
    logic allowed;

    // Reads of the addressed module count as active, not only the bridge report
    always_comb begin
        read_mods = modules_being_read_in;
        if (read_in.valid) begin
            read_mods[read_in.module_sel] = 1'b1;
        end
    end

    // Permission: never the module being read; module 4 only when reads spread
    always_comb begin
        allowed = !read_mods[op_in.module_sel];
        if (count_mods(read_mods) > 3'h1) begin
            allowed = allowed && (op_in.module_sel == fawc_pkg::DATA_MODULE);
        end
        if (op_in.module_sel > fawc_pkg::DATA_MODULE) begin
            allowed = 1'b0;
        end
    end

    // Wait count for a read; extension forced up when safe access is latched
    always_comb begin
        waits = {1'b0, base_access_wait_count_in} + {2'h0, access_wait_extension_in};
        if (safe_seen && access_wait_extension_in < fawc_pkg::EXT_SAFE) begin
            waits = waits + 4'h1;
        end
        if (read_in.cacheable) begin
            waits = read_in.cache_hit ? 4'h0 : waits + 4'h1;
        end else if (read_in.sequential) begin
            waits = 4'h0;
        end
    end

    // Read wait-state sequencer
    always_comb begin
        next_rbusy = rbusy;
        next_wcount = wcount;
        next_ready = 1'b0;
        next_erased = erased;
        next_safe_seen = safe_seen | safe_access_after_reset_in;
        // No retake while ready stands: the master still holds valid at that edge
        if (!rbusy && !ready && read_in.valid) begin
            // Erased status of the addressed module, latched when the read is taken
            if (read_in.module_sel <= fawc_pkg::DATA_MODULE) begin
                next_erased = !written[read_in.module_sel];
            end else begin
                next_erased = 1'b1;
            end
            if (waits == 4'h0) begin
                next_ready = 1'b1;
            end else begin
                next_rbusy = 1'b1;
                next_wcount = waits - 4'h1;
            end
        end else if (rbusy) begin
            if (wcount == 4'h0) begin
                next_rbusy = 1'b0;
                next_ready = 1'b1;
            end else begin
                next_wcount = wcount - 4'h1;
            end
        end
    end

    // Program/erase sequencer
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_op_mod = op_mod;
        next_written = written;
        next_busy = busy;
        next_accepted = 1'b0;
        next_refused = 1'b0;
        next_done = 1'b0;
        unique case (state)
            fawc_pkg::FAWC_IDLE: begin
                if (op_in.valid) begin
                    if (allowed) begin
                        next_accepted = 1'b1;
                        next_state = fawc_pkg::FAWC_WAIT;
                        next_op_mod = op_in.module_sel;
                        next_busy[op_in.module_sel] = 1'b1;
                        next_timer = op_in.erase ? 17'(ERASE_CYC - 1) : 17'(PROG_CYC - 1);
                        next_written[op_in.module_sel] = !op_in.erase;
                    end else begin
                        next_refused = 1'b1;
                    end
                end
            end
            fawc_pkg::FAWC_WAIT: begin
                if (timer == 17'h00000) begin
                    next_state = fawc_pkg::FAWC_DONE;
                    next_timer = 17'(fawc_pkg::SEQ_OVERHEAD - 1);
                end else begin
                    next_timer = timer - 17'h00001;
                end
            end
            fawc_pkg::FAWC_DONE: begin
                if (timer == 17'h00000) begin
                    next_state = fawc_pkg::FAWC_IDLE;
                    next_busy[op_mod] = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_timer = timer - 17'h00001;
                end
            end
            default: begin
                next_state = fawc_pkg::FAWC_IDLE;
            end
        endcase
    end

    // Register all state; reset gives erased, unprotected flash
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state <= fawc_pkg::FAWC_IDLE;
            timer <= 17'h00000;
            op_mod <= 3'h0;
            written <= fawc_pkg::MODS_NONE;
            busy <= fawc_pkg::MODS_NONE;
            accepted <= 1'b0;
            refused <= 1'b0;
            done <= 1'b0;
            wcount <= 4'h0;
            rbusy <= 1'b0;
            ready <= 1'b0;
            safe_seen <= 1'b0;
            erased <= 1'b1;
        end else begin
            state <= next_state;
            timer <= next_timer;
            op_mod <= next_op_mod;
            written <= next_written;
            busy <= next_busy;
            accepted <= next_accepted;
            refused <= next_refused;
            done <= next_done;
            wcount <= next_wcount;
            rbusy <= next_rbusy;
            ready <= next_ready;
            safe_seen <= next_safe_seen;
            erased <= next_erased;
        end
    end

    assign read_ready_out = ready;
    assign read_erased_out = erased;
    assign protect_active_out = 1'b0;
    assign op_accepted_out = accepted;
    assign op_refused_out = refused;
    assign op_done_out = done;
    assign busy_out = busy;

    // Checks
    sequence s_start;
        state == fawc_pkg::FAWC_IDLE && op_in.valid && allowed;
    endsequence
    property p_busy_set;
        @(posedge clock_in) disable iff (!nrst_in) s_start |=> busy[$past(op_in.module_sel)];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set");
    property p_no_read_target;
        @(posedge clock_in) disable iff (!nrst_in)
            (state == fawc_pkg::FAWC_IDLE && op_in.valid && read_mods[op_in.module_sel])
            |=> refused;
    endproperty
    a_no_read_target: assert property (p_no_read_target) else $error("read module written");
    property p_multi;
        @(posedge clock_in) disable iff (!nrst_in)
            (state == fawc_pkg::FAWC_IDLE && op_in.valid && count_mods(read_mods) > 3'h1
            && op_in.module_sel != fawc_pkg::DATA_MODULE) |=> !accepted;
    endproperty
    a_multi: assert property (p_multi) else $error("non-data module written");
    property p_seq_fast;
        @(posedge clock_in) disable iff (!nrst_in)
            (!rbusy && !ready && read_in.valid && read_in.sequential && !read_in.cacheable)
            |=> ready;
    endproperty
    a_seq_fast: assert property (p_seq_fast) else $error("sequential read waited");
    property p_hit;
        @(posedge clock_in) disable iff (!nrst_in)
            (!rbusy && !ready && read_in.valid && read_in.cacheable && read_in.cache_hit)
            |=> ready;
    endproperty
    a_hit: assert property (p_hit) else $error("cache hit waited");
    property p_done_clears;
        @(posedge clock_in) disable iff (!nrst_in) done |-> busy == fawc_pkg::MODS_NONE;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("busy stuck");
    property p_prog_time;
        @(posedge clock_in) disable iff (!nrst_in)
            $rose(state == fawc_pkg::FAWC_WAIT) && timer < 17'(PROG_CYC) |-> timer == 17'(PROG_CYC - 1);
    endproperty
    a_prog_time: assert property (p_prog_time) else $error("program timer wrong");
    property p_overhead;
        @(posedge clock_in) disable iff (!nrst_in)
            $rose(state == fawc_pkg::FAWC_DONE) |-> timer == 17'(fawc_pkg::SEQ_OVERHEAD - 1);
    endproperty
    a_overhead: assert property (p_overhead) else $error("overhead wrong");
    property p_erase_bound;
        @(posedge clock_in) disable iff (!nrst_in) timer <= 17'(ERASE_CYC - 1);
    endproperty
    a_erase_bound: assert property (p_erase_bound) else $error("erase over time");
endmodule

// ### fawc_pkg.sv
// Purpose: Shared constants and carriers for the flash access and wait-state control block
// Assumes: Single 10 MHz system clock, synchronous active-low reset
// Notes: Five flash modules; module 4 is the data-storage module
package fawc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int N_MODULES = 5;
    localparam logic [2:0] DATA_MODULE = 3'h4;
    // Longest erase and program times, in microseconds
    localparam int ERASE_MAX_US = 8000;
    localparam int PROG_MAX_US = 3500;
    // Longest times round down to whole cycles
    localparam int ERASE_CYCLES = (ERASE_MAX_US * (CLK_HZ / 1_000_000));
    localparam int PROG_CYCLES = (PROG_MAX_US * (CLK_HZ / 1_000_000));
    // Control state machine overhead per operation, in system clocks
    localparam int SEQ_OVERHEAD = 4;
    localparam logic [2:0] WAIT_RESET = 3'h4;
    localparam logic [1:0] EXT_RESET = 2'h0;
    localparam logic [1:0] EXT_SAFE = 2'h1;
    localparam logic [4:0] MODS_NONE = 5'h00;

    typedef enum logic [1:0] {
        FAWC_IDLE = 2'b00,
        FAWC_WAIT = 2'b01,
        FAWC_DONE = 2'b10
    } fawc_state_t;

    // Read request from the internal memory bridge
    typedef struct packed {
        logic valid;
        logic sequential;
        logic cacheable;
        logic cache_hit;
        logic [2:0] module_sel;
    } fawc_read_t;

    // Program or erase request from the sequencer control
    typedef struct packed {
        logic valid;
        logic erase;
        logic [2:0] module_sel;
    } fawc_op_t;
endpackage

// ### flash_access_waitstate_control_tb.sv
// Purpose: Self-checking bench for read wait states and program/erase arbitration
// Assumes: 10 MHz clock, erase and program counts shortened to 20 and 10
// Notes: Expected latencies follow the configured wait counts
`timescale 1ns/1ps
module flash_access_waitstate_control_tb;
    localparam int ER_T = 20;
    localparam int PR_T = 10;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [2:0] base_w = 3'h2;
    logic [1:0] ext_w = 2'h0;
    logic safe = 1'b0;
    logic [4:0] mods = 5'h00;
    logic ram = 1'b0;
    fawc_pkg::fawc_read_t rd_bus;
    fawc_pkg::fawc_op_t op = '0;
    logic ready, erased, protect, acc, refused, done;
    logic [4:0] busy;
    int error_cnt = 0;
    int num_checks = 0;

    // Clock runs free at 100 ns
    always #50 clock_in = ~clock_in;

    fawc_flash_ctrl #(.ERASE_CYC(ER_T), .PROG_CYC(PR_T)) i_dut (
        .clock_in(clock_in), .nrst_in(nrst_in), .read_in(rd_bus),
        .base_access_wait_count_in(base_w), .access_wait_extension_in(ext_w),
        .safe_access_after_reset_in(safe), .modules_being_read_in(mods),
        .program_ram_fetch_in(ram), .op_in(op), .read_ready_out(ready),
        .read_erased_out(erased), .protect_active_out(protect),
        .op_accepted_out(acc), .op_refused_out(refused), .op_done_out(done),
        .busy_out(busy));

    fawc_core_model i_core (.clock_in(clock_in), .ready_in(ready), .read_out(rd_bus));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Sets the wait configuration, fetches once and checks the latency
    task automatic rd(input logic [2:0] b, input logic [1:0] e, input logic s,
                      input logic [2:0] kind, input logic [2:0] m, input int exp);
        int lat;
        @(posedge clock_in);
        base_w <= b;
        ext_w <= e;
        safe <= s;
        i_core.fetch({1'b1, kind, m}, lat);
        check(lat, exp);
    endtask

    // One program or erase request, held for a single cycle
    task automatic do_op(input logic er, input logic [2:0] m, input logic ok, input int cyc);
        int n;
        n = 0;
        @(posedge clock_in);
        op <= '{valid: 1'b1, erase: er, module_sel: m};
        @(posedge clock_in);
        op <= '0;
        #1;
        check({acc, refused}, {ok, !ok});
        if (ok) begin
            check(busy, 5'h01 << m);
            while (done !== 1'b1 && n < 200) begin
                @(posedge clock_in);
                #1;
                n++;
            end
            check(n, cyc);
            check(busy, 5'h00);
        end
        repeat (3) @(posedge clock_in);
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        repeat (3000) @(posedge clock_in);
        error_cnt++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        #1;
        check({erased, protect, busy}, 7'h40);
        rd(3'h2, 2'h0, 1'b0, 3'h0, 3'h1, 3);
        rd(3'h2, 2'h0, 1'b0, 3'h4, 3'h1, 1);
        rd(3'h2, 2'h0, 1'b0, 3'h3, 3'h1, 1);
        rd(3'h2, 2'h0, 1'b0, 3'h2, 3'h1, 4);
        rd(3'h3, 2'h1, 1'b0, 3'h0, 3'h1, 5);
        rd(3'h3, 2'h1, 1'b0, 3'h2, 3'h1, 6);
        rd(3'h2, 2'h0, 1'b1, 3'h0, 3'h1, 4);
        do_op(1'b0, 3'h0, 1'b1, PR_T + fawc_pkg::SEQ_OVERHEAD);
        rd(3'h2, 2'h0, 1'b1, 3'h0, 3'h0, 4);
        check(erased, 1'b0);
        mods <= 5'h03;
        do_op(1'b1, 3'h4, 1'b1, ER_T + fawc_pkg::SEQ_OVERHEAD);
        do_op(1'b0, 3'h2, 1'b0, 0);
        do_op(1'b0, 3'h1, 1'b0, 0);
        mods <= 5'h04;
        do_op(1'b0, 3'h3, 1'b1, PR_T + fawc_pkg::SEQ_OVERHEAD);
        do_op(1'b1, 3'h2, 1'b0, 0);
        mods <= 5'h00;
        do_op(1'b1, 3'h5, 1'b0, 0);
        do_op(1'b1, 3'h0, 1'b1, ER_T + fawc_pkg::SEQ_OVERHEAD);
        rd(3'h2, 2'h0, 1'b1, 3'h0, 3'h0, 4);
        check(erased, 1'b1);
        report_and_stop();
    end
endmodule
